// >>> src/tetid_params.svh
// Register offsets, field positions, reset values and timing constants of the trigger block.
`ifndef TETID_PARAMS_SVH
`define TETID_PARAMS_SVH
`define TETID_ADDR_W 8
`define TETID_OFF_SLAVE_CTRL 8'h08
`define TETID_OFF_IRQ_DMA_EN 8'h0C
`define TETID_OFF_EVENT_FLAGS 8'h10
`define TETID_SLAVE_CTRL_RESET 16'h0000
`define TETID_IRQ_DMA_EN_RESET 16'h0000
`define TETID_IRQ_DMA_EN_MASK 16'h7FFF
`define TETID_FLAGS_MASK 16'h00FF
`define TETID_SMF_LSB 0
`define TETID_TRGSEL_LSB 4
`define TETID_MSMEN_BIT 7
`define TETID_FILT_LSB 8
`define TETID_PSC_LSB 12
`define TETID_EXT_CLOCK_MODE2_EN_BIT 14
`define TETID_POL_BIT 15
`define TETID_SMF_EXT_CLK1 3'h7
`define TETID_TRGSEL_EXT_TRIGGER_FILTERED 3'h7
`define TETID_TRGSEL_TI1FP1 3'h5
`define TETID_TRGSEL_TI2FP2 3'h6
`define TETID_TRGSEL_TIFED 3'h4
`define TETID_DTS_DIV 4'h1
`endif

// >>> src/tetid_pkg.sv
// Types shared by the external trigger conditioning and enable register block.
package tetid_pkg;
    typedef struct packed {
        logic ext_trig_polarity;
        logic ext_clock_mode2_en;
        logic [1:0] ext_trig_prescale_cfg;
        logic [3:0] ext_trig_filter_cfg;
        logic master_slave_en;
        logic [2:0] trigger_source_select;
        logic reserved3;
        logic [2:0] slave_function_select;
    } tetid_slave_ctrl_t;

    typedef struct packed {
        logic break_ev;
        logic trigger_ev;
        logic commutation_ev;
        logic [3:0] chan_ev;
        logic update_ev;
    } tetid_events_t;

    typedef struct packed {
        logic [5:0] div_log2;
        logic [3:0] length;
    } tetid_filt_sel_t;

    typedef enum logic [1:0] {
        TETID_CLK_INTERNAL = 2'b00,
        TETID_CLK_EXT_MODE1 = 2'b01,
        TETID_CLK_EXT_MODE2 = 2'b10
    } tetid_clk_src_t;
endpackage : tetid_pkg

// >>> src/tetid_top.sv
// External trigger conditioning, slave trigger select and event interrupt/DMA enables.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "tetid_params.svh"

module tetid_top (
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [`TETID_ADDR_W-1:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [15:0] RDATA_O,
    input wire logic EXT_TRIGGER_IN_I,
    input wire logic TIMER_FIVE_TRG_I,
    input wire logic TIMER_TWO_TRG_I,
    input wire logic TIMER_THREE_TRG_I,
    input wire logic TIMER_FOUR_TRG_I,
    input wire logic CHAN1_EDGE_I,
    input wire logic TI1FP1_I,
    input wire logic TI2FP2_I,
    input wire tetid_pkg::tetid_events_t EVENTS_I,
    input wire logic [2:0] CHAN_DMA_ACK_I,
    output logic EXT_TRIGGER_FILTERED_O,
    output logic SLAVE_TRIGGER_IN_O,
    output logic COUNT_TICK_O,
    output logic [1:0] CLK_SRC_O,
    output logic IRQ_O,
    output logic [6:0] DMA_REQ_O
);
    logic rst_s1_r;
    logic rst_n;
    logic [1:0] etr_sync_r;
    tetid_pkg::tetid_slave_ctrl_t slave_ctrl_r;
    logic [15:0] irq_dma_en_r;
    logic [7:0] flags_r;
    logic [15:0] rdata_r;
    logic etr_pol;
    logic etr_pol_d_r;
    logic [2:0] psc_cnt_r;
    logic ext_trigger_prescaled_r;
    logic [4:0] div_cnt_r;
    logic sample_tick;
    logic [3:0] agree_cnt_r;
    logic ext_trigger_filtered_r;
    logic ext_trigger_filtered_d_r;
    logic slave_trigger_in;
    logic slave_trigger_in_d_r;
    tetid_pkg::tetid_filt_sel_t fsel;
    logic [7:0] ev_vec;

    // Filter code to divider exponent and sample count.
    function automatic tetid_pkg::tetid_filt_sel_t filt_decode(input logic [3:0] code);
        tetid_pkg::tetid_filt_sel_t s;
        s.div_log2 = 6'h00;
        s.length = 4'h1;
        case (code)
            4'h0: begin s.div_log2 = 6'h00; s.length = 4'h1; end
            4'h1: begin s.div_log2 = 6'h00; s.length = 4'h2; end
            4'h2: begin s.div_log2 = 6'h00; s.length = 4'h4; end
            4'h3: begin s.div_log2 = 6'h00; s.length = 4'h8; end
            4'h4: begin s.div_log2 = 6'h01; s.length = 4'h6; end
            4'h5: begin s.div_log2 = 6'h01; s.length = 4'h8; end
            4'h6: begin s.div_log2 = 6'h02; s.length = 4'h6; end
            4'h7: begin s.div_log2 = 6'h02; s.length = 4'h8; end
            4'h8: begin s.div_log2 = 6'h03; s.length = 4'h6; end
            4'h9: begin s.div_log2 = 6'h03; s.length = 4'h8; end
            4'hA: begin s.div_log2 = 6'h04; s.length = 4'h5; end
            4'hB: begin s.div_log2 = 6'h04; s.length = 4'h6; end
            4'hC: begin s.div_log2 = 6'h04; s.length = 4'h8; end
            4'hD: begin s.div_log2 = 6'h05; s.length = 4'h5; end
            4'hE: begin s.div_log2 = 6'h05; s.length = 4'h6; end
            4'hF: begin s.div_log2 = 6'h05; s.length = 4'h8; end
            default: begin s.div_log2 = 6'h00; s.length = 4'h1; end
        endcase
        return s;
    endfunction : filt_decode

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // The trigger pin is asynchronous to the kernel clock.
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            etr_sync_r <= 2'b00;
        end else begin
            etr_sync_r <= {etr_sync_r[0], EXT_TRIGGER_IN_I};
        end
    end

    assign etr_pol = etr_sync_r[1] ^ slave_ctrl_r.ext_trig_polarity;

    // Prescaler counts active edges and toggles its output every 2^(k-1) edges.
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            etr_pol_d_r <= 1'b0;
            psc_cnt_r <= 3'h0;
            ext_trigger_prescaled_r <= 1'b0;
        end else begin
            etr_pol_d_r <= etr_pol;
            if (slave_ctrl_r.ext_trig_prescale_cfg == 2'b00) begin
                ext_trigger_prescaled_r <= etr_pol;
                psc_cnt_r <= 3'h0;
            end else if (etr_pol && !etr_pol_d_r) begin
                psc_cnt_r <= psc_cnt_r + 3'h1;
                case (slave_ctrl_r.ext_trig_prescale_cfg)
                    2'b01: ext_trigger_prescaled_r <= ~ext_trigger_prescaled_r;
                    2'b10: ext_trigger_prescaled_r <= psc_cnt_r[0] ? ~ext_trigger_prescaled_r : ext_trigger_prescaled_r;
                    2'b11: ext_trigger_prescaled_r <= (psc_cnt_r[1:0] == 2'b11) ? ~ext_trigger_prescaled_r : ext_trigger_prescaled_r;
                    default: ext_trigger_prescaled_r <= ext_trigger_prescaled_r;
                endcase
            end
        end
    end

    assign fsel = filt_decode(slave_ctrl_r.ext_trig_filter_cfg);

    // Sampling divider; the sampling clock is the kernel clock divided by 2^div_log2 here.
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= 5'h00;
        end else if (sample_tick) begin
            div_cnt_r <= 5'h00;
        end else begin
            div_cnt_r <= div_cnt_r + 5'h01;
        end
    end

    assign sample_tick = (div_cnt_r >= 5'((6'h01 << fsel.div_log2) - 6'h01));

    // Agreement counter: a short glitch restarts the count, so a glitch shorter than fsel.length samples never leaks through.
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            agree_cnt_r <= 4'h0;
            ext_trigger_filtered_r <= 1'b0;
        end else if (sample_tick) begin
            if (ext_trigger_prescaled_r == ext_trigger_filtered_r) begin
                agree_cnt_r <= 4'h0;
            end else if (agree_cnt_r + 4'h1 >= fsel.length) begin
                ext_trigger_filtered_r <= ext_trigger_prescaled_r;
                agree_cnt_r <= 4'h0;
            end else begin
                agree_cnt_r <= agree_cnt_r + 4'h1;
            end
        end
    end

    always_comb begin
        case (slave_ctrl_r.trigger_source_select)
            3'h0: slave_trigger_in = TIMER_FIVE_TRG_I;
            3'h1: slave_trigger_in = TIMER_TWO_TRG_I;
            3'h2: slave_trigger_in = TIMER_THREE_TRG_I;
            3'h3: slave_trigger_in = TIMER_FOUR_TRG_I;
            `TETID_TRGSEL_TIFED: slave_trigger_in = CHAN1_EDGE_I;
            `TETID_TRGSEL_TI1FP1: slave_trigger_in = TI1FP1_I;
            `TETID_TRGSEL_TI2FP2: slave_trigger_in = TI2FP2_I;
            default: slave_trigger_in = ext_trigger_filtered_r;
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            slave_trigger_in_d_r <= 1'b0;
            ext_trigger_filtered_d_r <= 1'b0;
            COUNT_TICK_O <= 1'b0;
            CLK_SRC_O <= 2'b00;
        end else begin
            slave_trigger_in_d_r <= slave_trigger_in;
            ext_trigger_filtered_d_r <= ext_trigger_filtered_r;
            if (slave_ctrl_r.ext_clock_mode2_en) begin
                COUNT_TICK_O <= ext_trigger_filtered_r && !ext_trigger_filtered_d_r;
                CLK_SRC_O <= tetid_pkg::TETID_CLK_EXT_MODE2;
            end else if (slave_ctrl_r.slave_function_select == `TETID_SMF_EXT_CLK1) begin
                COUNT_TICK_O <= slave_trigger_in && !slave_trigger_in_d_r;
                CLK_SRC_O <= tetid_pkg::TETID_CLK_EXT_MODE1;
            end else begin
                COUNT_TICK_O <= 1'b0;
                CLK_SRC_O <= tetid_pkg::TETID_CLK_INTERNAL;
            end
        end
    end

    assign EXT_TRIGGER_FILTERED_O = ext_trigger_filtered_r;
    assign SLAVE_TRIGGER_IN_O = slave_trigger_in;

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            slave_ctrl_r <= `TETID_SLAVE_CTRL_RESET;
            irq_dma_en_r <= `TETID_IRQ_DMA_EN_RESET;
        end else if (WR_I) begin
            if (ADDR_I == `TETID_OFF_SLAVE_CTRL) begin
                slave_ctrl_r <= WDATA_I;
            end
            if (ADDR_I == `TETID_OFF_IRQ_DMA_EN) begin
                irq_dma_en_r <= WDATA_I & `TETID_IRQ_DMA_EN_MASK;
            end
        end
    end

    assign ev_vec = EVENTS_I;

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= 8'h00;
        end else if (WR_I && ADDR_I == `TETID_OFF_EVENT_FLAGS) begin
            flags_r <= (flags_r & WDATA_I[7:0]) | ev_vec;
        end else begin
            flags_r <= flags_r | ev_vec;
        end
    end

    // Bit i of the enable word gates flag i onto the interrupt line.
    assign IRQ_O = |(flags_r & irq_dma_en_r[7:0]);

    // DMA requests hold while the flag stands; order: update, chan1-4, commutation, trigger.
    assign DMA_REQ_O = flags_r[6:0] & irq_dma_en_r[14:8];

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 16'h0000;
        end else if (RD_I) begin
            case (ADDR_I)
                `TETID_OFF_SLAVE_CTRL: rdata_r <= slave_ctrl_r;
                `TETID_OFF_IRQ_DMA_EN: rdata_r <= irq_dma_en_r;
                `TETID_OFF_EVENT_FLAGS: rdata_r <= {8'h00, flags_r};
                default: rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    assign RDATA_O = rdata_r;
endmodule : tetid_top

// >>> sim/tetid_assertions.sv
// Port-level checker for the trigger conditioning and enable register block.
`timescale 1ns/1ps
module tetid_assertions (
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [15:0] RDATA_O,
    input wire tetid_pkg::tetid_events_t EVENTS_I,
    input wire logic EXT_TRIGGER_FILTERED_O,
    input wire logic COUNT_TICK_O,
    input wire logic [1:0] CLK_SRC_O,
    input wire logic IRQ_O,
    input wire logic [6:0] DMA_REQ_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
        else $error("read data outside its answer cycle");
    unmapped_read_a: assert property (RD_I && ADDR_I != 8'h08 && ADDR_I != 8'h0C
        && ADDR_I != 8'h10 |=> RDATA_O == 16'h0000)
        else $error("unmapped read not zero");
    reserved_bit_a: assert property (RD_I && ADDR_I == 8'h0C |=> !RDATA_O[15])
        else $error("reserved enable bit reads one");
    tick_pulse_a: assert property (COUNT_TICK_O |=> !COUNT_TICK_O)
        else $error("count tick longer than one cycle");
    tick_source_a: assert property (COUNT_TICK_O |-> CLK_SRC_O != 2'h0)
        else $error("tick without external clock source");
    mode2_edge_a: assert property (CLK_SRC_O == 2'h2 && COUNT_TICK_O |->
        $past(EXT_TRIGGER_FILTERED_O) && !$past(EXT_TRIGGER_FILTERED_O, 2))
        else $error("mode two tick without filtered rising edge");
    irq_cause_a: assert property ($rose(IRQ_O) |-> $past(|EVENTS_I) || $past(WR_I))
        else $error("interrupt rose without event or write");
    irq_hold_a: assert property (IRQ_O && !WR_I |=> IRQ_O)
        else $error("interrupt dropped without a write");
    dma_cause_a: assert property ($rose(|DMA_REQ_O) |->
        $past(|EVENTS_I[6:0]) || $past(WR_I))
        else $error("dma request rose without event or write");
    cover property (COUNT_TICK_O && CLK_SRC_O == 2'h1);
    cover property (COUNT_TICK_O && CLK_SRC_O == 2'h2);
    cover property (IRQ_O && |DMA_REQ_O);
endmodule : tetid_assertions
bind tetid_top tetid_assertions tetid_assertions_i (.CORE_CLK_I(CORE_CLK_I),
    .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .EVENTS_I(EVENTS_I), .EXT_TRIGGER_FILTERED_O(EXT_TRIGGER_FILTERED_O),
    .COUNT_TICK_O(COUNT_TICK_O), .CLK_SRC_O(CLK_SRC_O), .IRQ_O(IRQ_O), .DMA_REQ_O(DMA_REQ_O));

// >>> sim/tetid_etr_src.sv
// Model of the external trigger pin source: bursts of equal high and low pulses.
`timescale 1ns/1ps
module tetid_etr_src (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [4:0] n_i,
    input wire logic [4:0] half_i,
    output logic pin_o,
    output logic busy_o
);
    logic [4:0] left_r = 5'h00;
    logic [4:0] cnt_r = 5'h00;
    initial pin_o = 1'b0;
    initial busy_o = 1'b0;
    // Callers keep half_i at two or more, so each pin period spans at least four clocks.
    always @(posedge clk_i) begin
        if (go_i) begin
            left_r <= n_i;
            cnt_r <= 5'h00;
            busy_o <= 1'b1;
        end else if (busy_o && cnt_r == half_i - 5'h01) begin
            cnt_r <= 5'h00;
            pin_o <= !pin_o;
            left_r <= left_r - {4'h0, pin_o};
            busy_o <= !(pin_o && left_r == 5'h01);
        end else if (busy_o) begin
            cnt_r <= cnt_r + 5'h01;
        end
    end
endmodule : tetid_etr_src

// >>> sim/timer_ext_trigger_irq_dma_enable_tb.sv
// Self-checking bench for the trigger conditioning and enable register block.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module timer_ext_trigger_irq_dma_enable_tb;
    logic clk, rst_n, wr, rd, go, busy, pin, ext_trigger_filtered, strg, tick, irq;
    logic [7:0] addr;
    logic [15:0] wd, rdat, d;
    logic [3:0] itrg;
    logic [4:0] n, half;
    logic [1:0] src;
    logic [6:0] dma;
    tetid_pkg::tetid_events_t ev;
    int num_errors = 0, total_checks = 0, ticks = 0, cyc = 0, t0;
    localparam logic [40:0] ROWS [8] = '{
        {1'b0, 8'h0C, 16'h0000, 16'h0000}, {1'b0, 8'h08, 16'h0000, 16'h0000},
        {1'b1, 8'h0C, 16'hFFFF, 16'h0000}, {1'b0, 8'h0C, 16'h0000, 16'h7FFF},
        {1'b1, 8'h0C, 16'h1234, 16'h0000}, {1'b1, 8'h04, 16'h5555, 16'h0000},
        {1'b0, 8'h04, 16'h0000, 16'h0000}, {1'b0, 8'h0C, 16'h0000, 16'h1234}};
    tetid_top tetid_top_i (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wd),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .EXT_TRIGGER_IN_I(pin),
        .TIMER_FIVE_TRG_I(itrg[0]), .TIMER_TWO_TRG_I(itrg[1]), .TIMER_THREE_TRG_I(itrg[2]),
        .TIMER_FOUR_TRG_I(itrg[3]), .CHAN1_EDGE_I(1'b0), .TI1FP1_I(1'b0), .TI2FP2_I(1'b0),
        .EVENTS_I(ev), .CHAN_DMA_ACK_I(3'h0), .EXT_TRIGGER_FILTERED_O(ext_trigger_filtered),
        .SLAVE_TRIGGER_IN_O(strg), .COUNT_TICK_O(tick), .CLK_SRC_O(src), .IRQ_O(irq),
        .DMA_REQ_O(dma));
    tetid_etr_src tetid_etr_src_i (.clk_i(clk), .go_i(go), .n_i(n), .half_i(half),
        .pin_o(pin), .busy_o(busy));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (tick === 1'b1) ticks++;
        if (cyc == 10000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    task automatic wr_t(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_t
    task automatic rd_t(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdat;
    endtask : rd_t
    // The settle wait covers the sync, prescale and longest filter used here.
    task automatic trig(input logic [15:0] c, input logic [4:0] cnt, input logic [4:0] hp,
        input int exp, input logic [1:0] s);
        int k;
        wr_t(8'h08, c);
        repeat (16) @(posedge clk);
        `CHK(src, s)
        t0 = ticks;
        n <= cnt;
        half <= hp;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        #1 k = 0;
        while (busy !== 1'b0 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        `CHK(busy, 1'b0)
        repeat (30) @(posedge clk);
        `CHK(ticks - t0, exp)
    endtask : trig
    initial begin
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; go = 1'b0; addr = 8'h00; wd = 16'h0000;
        itrg = 4'h0; ev = '0; n = 5'h00; half = 5'h04;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1 `CHK(irq, 1'b0)
        foreach (ROWS[i]) begin
            if (ROWS[i][40]) wr_t(ROWS[i][39:32], ROWS[i][31:16]);
            else begin
                rd_t(ROWS[i][39:32]);
                `CHK(d, ROWS[i][15:0])
            end
        end
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            wr_t(8'h0C, 16'h0001 << i);
            @(posedge clk);
            ev <= 8'h01 << i;
            @(posedge clk);
            ev <= 8'h00;
            #1 `CHK(irq, 1'b1)
            wr_t(8'h0C, ~(16'h0001 << i));
            #1 `CHK(irq, 1'b0)
            `CHK(dma, 7'(8'h01 << i))
            wr_t(8'h10, 16'h0000);
            #1 `CHK(dma, 7'h00)
        end
        $display("test enables done");
        for (int i = 0; i < 4; i++) begin
            wr_t(8'h08, 16'(i) << 4);
            @(posedge clk);
            itrg <= 4'h1 << i;
            #1 `CHK(strg, 1'b1)
            @(posedge clk);
            itrg <= ~(4'h1 << i);
            #1 `CHK(strg, 1'b0)
        end
        $display("test select done");
        for (int c = 0; c < 4; c++) trig(16'h4000 | (16'(c) << 12), 5'(2 << c), 5'h04, 2, 2'h2);
        trig(16'hC000, 5'h02, 5'h04, 2, 2'h2);
        #1 `CHK(ext_trigger_filtered, 1'b1)
        trig(16'h4300, 5'h01, 5'h03, 0, 2'h2);
        trig(16'h4300, 5'h01, 5'h10, 1, 2'h2);
        trig(16'h4000, 5'h02, 5'h04, 2, 2'h2);
        trig(16'h0077, 5'h02, 5'h04, 2, 2'h1);
        trig(16'h4077, 5'h02, 5'h04, 2, 2'h2);
        $display("test trigger done");
        // An event in the same cycle as a clearing write must leave the flag set.
        @(posedge clk);
        addr <= 8'h10;
        wd <= 16'h0000;
        wr <= 1'b1;
        ev <= 8'h01;
        @(posedge clk);
        wr <= 1'b0;
        ev <= 8'h00;
        #1 `CHK(irq, 1'b1)
        $display("test set wins done");
        rst_n <= 1'b0;
        @(posedge clk);
        #1 `CHK(irq, 1'b0)
        `CHK(src, 2'h0)
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_t(8'h0C);
        `CHK(d, 16'h0000)
        $display("test reset done");
        conclude();
    end
endmodule : timer_ext_trigger_irq_dma_enable_tb
